//--- rtl/jtp_pkg.sv
package jtp_pkg;
    localparam int IR_W = 4;
    localparam int ID_W = 32;
    localparam logic [3:0] IR_BYPASS = 4'hF;
    localparam logic [3:0] IR_IDCODE = 4'h1;
    localparam logic [3:0] IR_USERDR = 4'h2;
    // Pattern loaded in Capture-IR; the two low bits are fixed at 01.
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam logic [3:0] IR_RESET = IR_IDCODE;
    // Arbitrary identity value; bit 0 must stay set.
    localparam logic [31:0] IDCODE_DEFAULT = 32'h0000_A5A1;
    localparam logic SYNC_RESET_VAL = 1'b0;

    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
        ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR,
        ST_UPD_IR
    } jtp_state_t;
endpackage

//--- rtl/jtp_tap_if.sv
`timescale 1ns/10ps
interface jtp_tap_if;
    import jtp_pkg::*;
    logic tck_rise;
    logic tms;
    logic rst;
    jtp_state_t state;

    modport fsm (input tck_rise, input tms, input rst, output state);
    modport core (output tck_rise, output tms, output rst, input state);
endinterface

//--- rtl/jtp_tap_fsm.sv
`timescale 1ns/10ps
module jtp_tap_fsm
    import jtp_pkg::*;
(
    input wire logic mclk, // System clock.
    jtp_tap_if.fsm bus     // Edge strobe, steering input and state.
);
    jtp_state_t state_r;
    jtp_state_t state_nxt;

    assign bus.state = state_r;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_RESET: state_nxt = bus.tms ? ST_RESET : ST_IDLE;
            ST_IDLE: state_nxt = bus.tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_nxt = bus.tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_nxt = bus.tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: state_nxt = bus.tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_nxt = bus.tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: state_nxt = bus.tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: state_nxt = bus.tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: state_nxt = bus.tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_nxt = bus.tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: state_nxt = bus.tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: state_nxt = bus.tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_nxt = bus.tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: state_nxt = bus.tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: state_nxt = bus.tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: state_nxt = bus.tms ? ST_SEL_DR : ST_IDLE;
        endcase
    end

    // Five rising edges with the steering input high reach the reset
    // state from anywhere, so the optional reset pin is never needed.
    always_ff @(posedge mclk) begin
        if (bus.rst) begin
            state_r <= ST_RESET;
        end else if (bus.tck_rise) begin
            state_r <= state_nxt;
        end
    end
endmodule

//--- rtl/jtp_tap.sv
// How it works
// - Serial input bits are taken on each rising test clock edge.
// - The serial output changes only on falling test clock edges.
// - Serial output is released unless an IR or DR shift is active.
// - Steering input is sampled on rising test clock; host sets it first.
// - Controller moves only on rising test clock, steered by one input.
// - Low test reset forces the controller reset without any test clock.
// - Test reset is optional; five steering highs also reach reset.
`timescale 1ns/10ps
module jtp_tap
    import jtp_pkg::*;
#(
    parameter int USER_W = 8,
    parameter logic [31:0] IDCODE = IDCODE_DEFAULT
)(
    input wire logic mclk,                  // System clock, 25 MHz.
    input wire logic reset,                 // Synchronous reset, high.
    input wire logic tck,                   // Test clock pin.
    input wire logic tms,                   // Test mode select pin.
    input wire logic tdi,                   // Test data in pin.
    input wire logic trst_n,                // Test reset pin, low.
    output logic tdo,                       // Test data out value.
    output logic tdo_oe,                    // High while driving data out.
    output logic [USER_W-1:0] user_data,    // Updated user register.
    output logic [IR_W-1:0] instr           // Active instruction.
);
    logic tck_s1_r, tck_s2_r, tck_s3_r;
    logic tms_s1_r, tms_s2_r;
    logic tdi_s1_r, tdi_s2_r;
    logic trst_s1_r, trst_s2_r;
    logic tck_fall;
    logic tap_rst;
    logic [IR_W-1:0] ir_sh_r;
    logic [IR_W-1:0] instr_r;
    logic byp_r;
    logic [ID_W-1:0] id_sh_r;
    logic [USER_W-1:0] usr_sh_r;
    logic [USER_W-1:0] user_r;
    logic tdo_r;
    logic tdo_oe_r;

    jtp_tap_if bus ();

    function automatic logic dr_out(input logic [IR_W-1:0] ins,
                                    input logic byp,
                                    input logic id0,
                                    input logic us0);
        logic r;
        r = byp;
        if (ins == IR_IDCODE) begin
            r = id0;
        end else if (ins == IR_USERDR) begin
            r = us0;
        end
        return r;
    endfunction

    // Every pin crosses two flops; the edge finder reads only the second
    // and third stages, so the test clock must stay below mclk / 4.
    always_ff @(posedge mclk) begin
        if (reset) begin
            tck_s1_r <= SYNC_RESET_VAL;
            tck_s2_r <= SYNC_RESET_VAL;
            tck_s3_r <= SYNC_RESET_VAL;
            tms_s1_r <= SYNC_RESET_VAL;
            tms_s2_r <= SYNC_RESET_VAL;
            tdi_s1_r <= SYNC_RESET_VAL;
            tdi_s2_r <= SYNC_RESET_VAL;
            trst_s1_r <= SYNC_RESET_VAL;
            trst_s2_r <= SYNC_RESET_VAL;
        end else begin
            tck_s1_r <= tck;
            tck_s2_r <= tck_s1_r;
            tck_s3_r <= tck_s2_r;
            tms_s1_r <= tms;
            tms_s2_r <= tms_s1_r;
            tdi_s1_r <= tdi;
            tdi_s2_r <= tdi_s1_r;
            trst_s1_r <= trst_n;
            trst_s2_r <= trst_s1_r;
        end
    end

    // The reset pin acts whatever the test clock does; only mclk is needed.
    assign tap_rst = reset | ~trst_s2_r;
    assign bus.rst = tap_rst;
    assign bus.tck_rise = tck_s2_r & ~tck_s3_r;
    assign bus.tms = tms_s2_r;
    assign tck_fall = ~tck_s2_r & tck_s3_r;

    jtp_tap_fsm u_fsm (
        .mclk(mclk),
        .bus(bus)
    );

    // Instruction path; the reset state restores the default instruction.
    always_ff @(posedge mclk) begin
        if (tap_rst) begin
            ir_sh_r <= IR_CAPTURE;
            instr_r <= IR_RESET;
        end else if (bus.tck_rise) begin
            unique case (bus.state)
                ST_RESET: instr_r <= IR_RESET;
                ST_CAP_IR: ir_sh_r <= IR_CAPTURE;
                ST_SH_IR: ir_sh_r <= {tdi_s2_r, ir_sh_r[IR_W-1:1]};
                ST_UPD_IR: instr_r <= ir_sh_r;
                default: ;
            endcase
        end
    end

    // Data paths; unknown instructions fall back to the one-bit bypass.
    always_ff @(posedge mclk) begin
        if (tap_rst) begin
            byp_r <= 1'b0;
            id_sh_r <= IDCODE;
            usr_sh_r <= '0;
            user_r <= '0;
        end else if (bus.tck_rise) begin
            if (bus.state == ST_CAP_DR) begin
                byp_r <= 1'b0;
                id_sh_r <= IDCODE;
                usr_sh_r <= user_r;
            end else if (bus.state == ST_SH_DR) begin
                if (instr_r == IR_IDCODE) begin
                    id_sh_r <= {tdi_s2_r, id_sh_r[ID_W-1:1]};
                end else if (instr_r == IR_USERDR) begin
                    usr_sh_r <= {tdi_s2_r, usr_sh_r[USER_W-1:1]};
                end else begin
                    byp_r <= tdi_s2_r;
                end
            end else if (bus.state == ST_UPD_DR &&
                         instr_r == IR_USERDR) begin
                user_r <= usr_sh_r;
            end
        end
    end

    // Driving on the falling edge gives the host a half period of hold.
    always_ff @(posedge mclk) begin
        if (tap_rst) begin
            tdo_r <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else if (tck_fall) begin
            if (bus.state == ST_SH_IR) begin
                tdo_r <= ir_sh_r[0];
                tdo_oe_r <= 1'b1;
            end else if (bus.state == ST_SH_DR) begin
                tdo_r <= dr_out(instr_r, byp_r, id_sh_r[0], usr_sh_r[0]);
                tdo_oe_r <= 1'b1;
            end else begin
                tdo_oe_r <= 1'b0;
            end
        end
    end

    assign tdo = tdo_r;
    assign tdo_oe = tdo_oe_r;
    assign user_data = user_r;
    assign instr = instr_r;
endmodule

//--- verification/jtp_tap_sva.sv
`timescale 1ns/10ps
module jtp_tap_sva
    import jtp_pkg::*;
#(parameter int USER_W = 8)(
    input wire logic mclk, // Clock.
    input wire logic reset, // Reset.
    input wire logic tck, // Test clock.
    input wire logic tms, // Mode select.
    input wire logic tdi, // Data in.
    input wire logic trst_n, // Test reset.
    input wire logic tdo, // Data out.
    input wire logic tdo_oe, // Out enable.
    input wire logic [USER_W-1:0] user_data, // User register.
    input wire logic [IR_W-1:0] instr // Instruction.
);
    logic t1, t2, m1;
    logic [3:0] fc, rc, qc;
    logic [2:0] hc;
    logic rise;
    assign rise = t1 & ~t2;
    always_ff @(posedge mclk) begin
        t1 <= tck;
        t2 <= t1;
        m1 <= tms;
    end
    // fc and rc give the age of the last seen test clock edges in cycles; hc counts successive rises with mode high.
    always_ff @(posedge mclk) begin
        if (reset) begin
            fc <= 4'hF;
            rc <= 4'hF;
            hc <= 3'h0;
        end else begin
            fc <= (t2 & ~t1) ? 4'h0 : fc + {3'h0, fc != 4'hF};
            rc <= rise ? 4'h0 : rc + {3'h0, rc != 4'hF};
            if (rise)
                hc <= m1 ? hc + {2'h0, hc != 3'h5} : 3'h0;
        end
    end
    // Edge-age checks wait until the reset synchronisers have settled.
    always_ff @(posedge mclk) begin
        if (reset || !trst_n)
            qc <= 4'h0;
        else
            qc <= qc + {3'h0, qc != 4'h8};
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    chk_tdo_on_fall: assert property (qc == 4'h8 && tdo_oe &&
        $past(tdo_oe) && $changed(tdo) |-> fc <= 4'h5)
        else $error("data out moved away from a falling test clock");
    chk_oe_on_fall: assert property (qc == 4'h8 && $changed(tdo_oe)
        |-> fc <= 4'h5) else $error("enable moved off a falling edge");
    chk_instr_on_rise: assert property (qc == 4'h8 &&
        $changed(instr) |-> rc <= 4'h5)
        else $error("instruction moved off a rising edge");
    chk_user_on_rise: assert property (qc == 4'h8 &&
        $changed(user_data) |-> rc <= 4'h5)
        else $error("user register moved off a rising edge");
    chk_trst_reset: assert property ($fell(trst_n) |->
        ##[1:4] (instr == IR_RESET && !tdo_oe))
        else $error("test reset did not reset the controller");
    chk_sync_reset: assert property ($fell(reset) |-> !tdo_oe &&
        user_data == '0 && instr == IR_RESET)
        else $error("reset values wrong");
    chk_trst_idle: assert property (!trst_n [*5] |->
        !tdo_oe && instr == IR_RESET) else $error("held test reset busy");
    chk_tms_reset: assert property (qc == 4'h8 && rise && m1 &&
        hc == 3'h4 |-> ##[1:6] instr == IR_RESET)
        else $error("five mode highs did not reset");
endmodule
bind jtp_tap jtp_tap_sva #(.USER_W(USER_W)) chk (.mclk(mclk), .reset(reset),
    .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
    .tdo_oe(tdo_oe), .user_data(user_data), .instr(instr));

//--- verification/jtp_host.sv
`timescale 1ns/10ps
module jtp_host (
    input wire logic mclk, // Clock.
    input wire logic tdo, // Data out pin.
    input wire logic tdo_oe, // Data out enable.
    output logic tck, // Test clock.
    output logic tms, // Mode select.
    output logic tdi, // Data in.
    output logic trst_n // Test reset, low.
);
    logic flip = 1'b1;
    // A released pin toggles so stale data can never pass as a match.
    always @(posedge mclk)
        flip <= ~flip;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        trst_n = 1'b0;
    end
    // One 320 ns test clock period; the clock parks low between calls.
    // The pins are read four cycles after the fall, once the answer stands.
    task automatic step(input logic m, d, output logic o, e);
        @(posedge mclk);
        tms <= m;
        tdi <= d;
        repeat (3) @(posedge mclk);
        o = tdo_oe ? tdo : flip;
        e = tdo_oe;
        tck <= 1'b1;
        repeat (4) @(posedge mclk);
        tck <= 1'b0;
    endtask
endmodule

//--- verification/test_jtp_tap.sv
`timescale 1ns/10ps
module test_jtp_tap;
    import jtp_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic tck, tms, tdi, trst_n, tdo, tdo_oe, o, e;
    logic [7:0] user_data;
    logic [3:0] instr;
    logic [31:0] got, val, prev;
    int n_errors = 0;
    int n_checks = 0;
    int seed = 32'h2abd;
    int k;
    always #20 mclk = ~mclk;
    jtp_tap uut (.mclk(mclk), .reset(reset), .tck(tck), .tms(tms),
        .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
        .user_data(user_data), .instr(instr));
    jtp_host h (.mclk(mclk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck),
        .tms(tms), .tdi(tdi), .trst_n(trst_n));
    task automatic check(input logic [31:0] g, x, input string m);
        n_checks++;
        if (g !== x) begin
            n_errors++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic scan(input logic ir, input int n, input logic [31:0] d);
        got = '0;
        h.step(1'b1, 1'b0, o, e);
        if (ir)
            h.step(1'b1, 1'b0, o, e);
        repeat (2) h.step(1'b0, 1'b0, o, e);
        for (int i = 0; i < n; i++) begin
            h.step(i == n - 1, d[i], o, e);
            got[i] = o;
            check(e, 1, "shift enable");
        end
        h.step(1'b1, 1'b0, o, e);
        h.step(1'b0, 1'b0, o, e);
        check(e, 0, "idle enable");
    endtask
    initial begin
        #1000000;
        n_errors++;
        finish_test;
    end
    initial begin
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        h.trst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        check(instr, IR_RESET, "reset instruction");
        // The controller wakes in its reset state; one low step reaches idle.
        h.step(1'b0, 1'b0, o, e);
        scan(1, IR_W, IR_USERDR);
        check(got, IR_CAPTURE, "ir capture");
        check(instr, IR_USERDR, "ir update");
        prev = 0;
        for (k = 0; k < 6; k++) begin
            val = (k < 2) ? {24'h0, {8{k[0]}}} : $random(seed) & 32'hFF;
            scan(0, 8, val);
            check(got, prev, "user capture");
            check(user_data, val, "user update");
            prev = val;
        end
        scan(1, IR_W, IR_BYPASS);
        val = $random(seed);
        scan(0, 8, val);
        check(got, {val[6:0], 1'b0}, "bypass");
        scan(1, IR_W, IR_IDCODE);
        scan(0, ID_W, ~IDCODE_DEFAULT);
        check(got, IDCODE_DEFAULT, "identity");
        scan(1, IR_W, IR_USERDR);
        repeat (5) h.step(1'b1, 1'b0, o, e);
        check(instr, IR_RESET, "mode reset");
        h.step(1'b0, 1'b0, o, e);
        scan(1, IR_W, IR_USERDR);
        h.step(1'b1, 1'b0, o, e);
        repeat (3) h.step(1'b0, 1'b1, o, e);
        h.trst_n <= 1'b0;
        repeat (6) @(posedge mclk);
        check(instr, IR_RESET, "test reset");
        check(tdo_oe, 0, "test reset enable");
        h.trst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        h.step(1'b0, 1'b0, o, e);
        finish_test;
    end
endmodule
